// [rtl_trigger.sv]
// recorder trigger unit: arming, trigger evaluation, pre/post sample counting, APB registers
// assumes an APB master on pclk and a signed source sample valid at every sample tick
// Function
// [R1] type 0 starts recording at once when the arm command arrives
// [R2] type 1 triggers on the next host command after arming
// [R3] type 2 triggers when the source crosses threshold with chosen slope
// [R4] type 3 triggers on a chosen one-bit source level
// [R5] pretrigger percent of samples precede trigger, the rest at or after
// [R6] pretrigger percentage is ignored for the immediate type
// [R7] threshold used only in signal mode; boolean takes polarity from slope
// [R8] positive slope: previous sample below threshold, current at or above
// [R9] negative slope: previous sample above threshold, current at or below
// [R10] decimation above one with pretrigger: evaluate once every N samples
// [R11] zero pretrigger: evaluate trigger on every base sample
// [R12] boolean: positive slope fires on 1, negative slope fires on 0
// [R13] boolean trigger is level sensitive, fires at once if already matching
// [R14] after trigger capture the post share, then stop and report complete
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rtl_consts.svh"
module rtl_trigger
  import rtl_pkg::*;
#(
  parameter int SW          = 16,
  parameter int CW          = 16,
  parameter int TICK_CYCLES = `RTL_TICK_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic               pslverr,
  output logic [31:0]        prdata,
  input  wire logic [SW-1:0] source_sample,
  input  wire logic          source_bit,
  output logic               sample_tick,
  output logic               capture_strobe,
  output logic               triggered,
  output logic               recording_done
);
  if (SW < 2 || SW > 32 || CW < 8 || CW > 24 || TICK_CYCLES < 1) begin : g_param_check
    $error("rtl_trigger: unsupported parameter values");
  end

  // --- registers
  logic [1:0]        trigger_type_select_r;
  logic              trigger_polarity_r;
  logic [6:0]        pretrigger_percent_r;
  logic [SW-1:0]     trigger_threshold_r;
  logic [CW-1:0]     sample_count_r;
  logic [15:0]       sample_decimation_r;
  rtl_state_t        state_r;
  logic [CW-1:0]     pre_cnt_r;
  logic [CW-1:0]     post_cnt_r;
  logic [CW-1:0]     pre_target_r;
  logic [CW-1:0]     post_target_r;
  logic [15:0]       gap_cnt_r;
  logic [SW-1:0]     prev_sample_r;
  logic              prev_valid_r;
  logic [CW-1:0]     trig_index_r;
  logic [31:0]       tick_cnt_r;
  logic              host_cmd_seen_r;
  logic              done_r;

  // --- APB
  logic wr_en;
  logic rd_en;
  logic arm_cmd;
  logic host_cmd;
  logic abort_cmd;
  assign wr_en     = psel && penable && pwrite;
  // read data is loaded in the setup cycle so it already stands at the completing edge
  assign rd_en     = psel && !penable && !pwrite;
  assign pready    = 1'b1;
  assign arm_cmd   = wr_en && (paddr == `RTL_OFF_CMD) && pwdata[`RTL_CMD_ARM_BIT];
  // any write from the host that is not the arm itself counts as "next command"
  assign host_cmd  = wr_en && !arm_cmd;
  assign abort_cmd = wr_en && (paddr == `RTL_OFF_CMD) && pwdata[`RTL_CMD_ABORT_BIT];

  function automatic logic addr_mapped(input logic [11:0] a);
    return a == `RTL_OFF_CTRL || a == `RTL_OFF_THRESH || a == `RTL_OFF_COUNT ||
           a == `RTL_OFF_DECIM || a == `RTL_OFF_CMD || a == `RTL_OFF_STATUS ||
           a == `RTL_OFF_SOURCE || a == `RTL_OFF_TRIGIDX;
  endfunction

  assign pslverr = psel && penable && !addr_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_type_select_r <= `RTL_TYPE_IMMED;
      trigger_polarity_r    <= 1'b0;
      pretrigger_percent_r  <= 7'h00;
      trigger_threshold_r   <= '0;
      sample_count_r        <= CW'(`RTL_RST_COUNT);
      sample_decimation_r   <= `RTL_RST_DECIM;
    end else if (wr_en && state_r != RTL_PRE && state_r != RTL_WAIT && state_r != RTL_POST) begin
      // settings frozen while a recording is in progress
      if (paddr == `RTL_OFF_CTRL) begin
        trigger_type_select_r <= pwdata[`RTL_CTRL_TYPE_LSB +: 2];
        trigger_polarity_r    <= pwdata[`RTL_CTRL_POL_BIT];
        pretrigger_percent_r  <= (pwdata[`RTL_CTRL_PCT_LSB +: 7] > `RTL_PCT_MAX) ?
                                 `RTL_PCT_MAX : pwdata[`RTL_CTRL_PCT_LSB +: 7];
      end else if (paddr == `RTL_OFF_THRESH) begin
        trigger_threshold_r <= pwdata[SW-1:0];
      end else if (paddr == `RTL_OFF_COUNT) begin
        sample_count_r <= (pwdata[CW-1:0] == '0) ? CW'(1) : pwdata[CW-1:0];
      end else if (paddr == `RTL_OFF_DECIM) begin
        sample_decimation_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      if (paddr == `RTL_OFF_CTRL) begin
        prdata <= {17'h00000, pretrigger_percent_r, 5'h00, trigger_polarity_r, trigger_type_select_r};
      end else if (paddr == `RTL_OFF_THRESH) begin
        prdata <= 32'(trigger_threshold_r);
      end else if (paddr == `RTL_OFF_COUNT) begin
        prdata <= 32'(sample_count_r);
      end else if (paddr == `RTL_OFF_DECIM) begin
        prdata <= {16'h0000, sample_decimation_r};
      end else if (paddr == `RTL_OFF_STATUS) begin
        prdata <= {27'h0000000, done_r, state_r == RTL_POST, state_r == RTL_WAIT,
                   state_r == RTL_PRE, state_r == RTL_IDLE};
      end else if (paddr == `RTL_OFF_SOURCE) begin
        prdata <= 32'(source_sample);
      end else if (paddr == `RTL_OFF_TRIGIDX) begin
        prdata <= 32'(trig_index_r);
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // --- base sample tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h00000000;
    end else if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end
  assign sample_tick = (tick_cnt_r == 32'h00000000);

  // --- decimation: capture and evaluation slots
  logic gap_slot;
  assign gap_slot = sample_tick && (gap_cnt_r == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt_r <= 16'h0000;
    end else if (arm_cmd && state_r != RTL_PRE && state_r != RTL_WAIT && state_r != RTL_POST) begin
      gap_cnt_r <= 16'h0000;
    end else if (sample_tick) begin
      gap_cnt_r <= (gap_cnt_r + 16'h0001 >= sample_decimation_r) ? 16'h0000 : gap_cnt_r + 16'h0001;
    end
  end

  logic eval_slot;
  // zero pretrigger evaluates each base sample; otherwise only recorded samples
  assign eval_slot = (pretrigger_percent_r == 7'h00) ? sample_tick : gap_slot; // [R10] [R11]

  // --- previous evaluated sample for crossing detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_sample_r <= '0;
      prev_valid_r  <= 1'b0;
    end else if (state_r == RTL_IDLE || state_r == RTL_DONE) begin
      prev_valid_r <= 1'b0;
    end else if (eval_slot) begin
      prev_sample_r <= source_sample;
      prev_valid_r  <= 1'b1;
    end
  end

  function automatic logic crossing(input logic [SW-1:0] prv, input logic [SW-1:0] cur,
                                    input logic [SW-1:0] thr, input logic pos);
    if (pos)
      return ($signed(prv) < $signed(thr)) && ($signed(cur) >= $signed(thr));
    else
      return ($signed(prv) > $signed(thr)) && ($signed(cur) <= $signed(thr));
  endfunction

  // --- host command detection while in pre or wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_cmd_seen_r <= 1'b0;
    end else if (state_r != RTL_WAIT && state_r != RTL_PRE) begin
      host_cmd_seen_r <= 1'b0;
    end else if (host_cmd) begin
      host_cmd_seen_r <= 1'b1;
    end
  end

  logic trig_cond;
  always_comb begin
    trig_cond = 1'b0;
    case (trigger_type_select_r)
      `RTL_TYPE_IMMED:   trig_cond = 1'b1; // [R1]
      `RTL_TYPE_NEXTCMD: trig_cond = host_cmd_seen_r || host_cmd; // [R2]
      `RTL_TYPE_SIGNAL:  trig_cond = eval_slot && prev_valid_r &&
                                     crossing(prev_sample_r, source_sample, trigger_threshold_r,
                                              trigger_polarity_r); // [R3] [R7] [R8] [R9]
      // level compare, no edge needed: matches on arrival fire at once
      default:           trig_cond = eval_slot && (source_bit == trigger_polarity_r); // [R4] [R12] [R13]
    endcase
  end

  // --- pre/post targets
  logic [CW+7:0] pre_prod;
  logic [CW-1:0] pre_calc;
  assign pre_prod = (CW+8)'(sample_count_r) * (CW+8)'(pretrigger_percent_r);
  assign pre_calc = (trigger_type_select_r == `RTL_TYPE_IMMED) ? '0 :
                    CW'(pre_prod / (CW+8)'(`RTL_PCT_MAX)); // [R5] [R6]

  logic recording;
  assign recording = (state_r == RTL_PRE || state_r == RTL_WAIT || state_r == RTL_POST);
  assign capture_strobe = recording && gap_slot;

  logic fire;
  assign fire = (state_r == RTL_WAIT) && trig_cond;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= RTL_IDLE;
      pre_cnt_r     <= '0;
      post_cnt_r    <= '0;
      pre_target_r  <= '0;
      post_target_r <= '0;
      trig_index_r  <= '0;
    end else if (abort_cmd) begin
      state_r <= RTL_IDLE;
    end else begin
      case (state_r)
        RTL_IDLE, RTL_DONE: begin
          if (arm_cmd) begin
            pre_cnt_r     <= '0;
            post_cnt_r    <= '0;
            pre_target_r  <= pre_calc;
            post_target_r <= sample_count_r - pre_calc; // [R5]
            state_r       <= (pre_calc == '0) ? RTL_WAIT : RTL_PRE; // [R1]
          end
        end
        RTL_PRE: begin
          if (capture_strobe) begin
            pre_cnt_r <= pre_cnt_r + CW'(1);
            if (pre_cnt_r + CW'(1) >= pre_target_r)
              state_r <= RTL_WAIT;
          end
        end
        RTL_WAIT: begin
          if (fire) begin
            trig_index_r <= pre_cnt_r;
            state_r      <= RTL_POST;
          end else if (capture_strobe && pre_cnt_r < pre_target_r) begin
            pre_cnt_r <= pre_cnt_r + CW'(1);
          end
        end
        RTL_POST: begin
          if (capture_strobe) begin
            post_cnt_r <= post_cnt_r + CW'(1);
            if (post_cnt_r + CW'(1) >= post_target_r)
              state_r <= RTL_DONE; // [R14]
          end
        end
        default: state_r <= RTL_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (state_r == RTL_POST && capture_strobe && post_cnt_r + CW'(1) >= post_target_r) begin
      done_r <= 1'b1; // [R14]
    end else if (arm_cmd || abort_cmd) begin
      done_r <= 1'b0;
    end
  end

  assign triggered      = (state_r == RTL_POST) || (state_r == RTL_DONE);
  assign recording_done = done_r;

  // --- assertions
  immed_no_pre_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    (state_r == RTL_IDLE && arm_cmd && !abort_cmd && trigger_type_select_r == `RTL_TYPE_IMMED)
      |=> state_r == RTL_WAIT ##1 state_r == RTL_POST)
    else $error("immediate trigger did not fire right after arming");
  immed_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (state_r == RTL_WAIT && trigger_type_select_r == `RTL_TYPE_IMMED && !abort_cmd) |=> triggered)
    else $error("immediate type waited");
  nextcmd_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (state_r == RTL_WAIT && trigger_type_select_r == `RTL_TYPE_NEXTCMD && host_cmd && !abort_cmd)
      |=> state_r == RTL_POST)
    else $error("host command did not trigger");
  pos_cross_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    (fire && trigger_type_select_r == `RTL_TYPE_SIGNAL && trigger_polarity_r)
      |-> $signed(prev_sample_r) < $signed(trigger_threshold_r) &&
          $signed(source_sample) >= $signed(trigger_threshold_r))
    else $error("positive slope fired without crossing");
  neg_cross_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    (fire && trigger_type_select_r == `RTL_TYPE_SIGNAL && !trigger_polarity_r)
      |-> $signed(prev_sample_r) > $signed(trigger_threshold_r) &&
          $signed(source_sample) <= $signed(trigger_threshold_r))
    else $error("negative slope fired without crossing");
  bool_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (state_r == RTL_WAIT && trigger_type_select_r == `RTL_TYPE_BOOL && eval_slot &&
     source_bit == trigger_polarity_r && !abort_cmd) |=> state_r == RTL_POST)
    else $error("boolean level did not fire");
  gap_eval_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (fire && trigger_type_select_r == `RTL_TYPE_SIGNAL && pretrigger_percent_r != 7'h00) |-> gap_slot)
    else $error("evaluation outside decimation slot");
  pre_count_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (state_r == RTL_POST && $past(state_r) == RTL_WAIT) |-> trig_index_r <= pre_target_r)
    else $error("pretrigger count exceeded target");
  done_total_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
    $rose(done_r) |-> post_cnt_r == post_target_r && state_r == RTL_DONE)
    else $error("done without full post share");
endmodule

// [rtl_consts.svh]
// offsets, field positions, reset values and timing counts for the recorder trigger unit
// assumes inclusion by the package, the design file and the test bench
`ifndef RTL_CONSTS_SVH
`define RTL_CONSTS_SVH
`define RTL_OFF_CTRL      12'h000
`define RTL_OFF_THRESH    12'h004
`define RTL_OFF_COUNT     12'h008
`define RTL_OFF_DECIM     12'h00C
`define RTL_OFF_CMD       12'h010
`define RTL_OFF_STATUS    12'h014
`define RTL_OFF_SOURCE    12'h018
`define RTL_OFF_TRIGIDX   12'h01C
`define RTL_TYPE_IMMED    2'h0
`define RTL_TYPE_NEXTCMD  2'h1
`define RTL_TYPE_SIGNAL   2'h2
`define RTL_TYPE_BOOL     2'h3
`define RTL_CTRL_TYPE_LSB 0
`define RTL_CTRL_POL_BIT  2
`define RTL_CTRL_PCT_LSB  8
`define RTL_CMD_ARM_BIT   0
`define RTL_CMD_HOST_BIT  1
`define RTL_CMD_ABORT_BIT 2
`define RTL_PCT_MAX       7'h64
`define RTL_RST_COUNT     16'h03E8
`define RTL_RST_DECIM     16'h0001
`define RTL_SAMPLE_HZ     16000
`define RTL_CLK_HZ        125000000
`define RTL_TICK_CYCLES   (`RTL_CLK_HZ / `RTL_SAMPLE_HZ)
`endif

// [rtl_pkg.sv]
// types shared by the recorder trigger unit
// assumes rtl_consts.svh sits in the same folder
`include "rtl_consts.svh"
package rtl_pkg;
  typedef enum logic [2:0] {
    RTL_IDLE,
    RTL_PRE,
    RTL_WAIT,
    RTL_POST,
    RTL_DONE
  } rtl_state_t;
endpackage

// [rtl_host_model.sv]
// host side of the recorder trigger unit: an APB master that issues settings and commands
// assumes a slave on pclk whose read data stands at the edge that completes the access
`timescale 1ns/1ps
module rtl_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // read data and error flag are taken at the completing edge, then the request is released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    e = (n >= 50) ? 1'bx : pslverr;
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [recorder_trigger_logic_test.sv]
// self-checking bench for the recorder trigger unit: table of trigger setups, then abort and reset
// assumes rtl_trigger with a 4-cycle sample tick and the host model above
`timescale 1ns/1ps
`include "rtl_consts.svh"
module recorder_trigger_logic_test;
  typedef struct packed {
    logic [1:0]  ty;
    logic        pol;
    logic [6:0]  pct;
    logic [15:0] cnt;
    logic [15:0] dec;
    logic [15:0] thr;
    logic        sb;
    logic [15:0] es;
  } rtl_row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        source_bit = 1'b0;
  logic [15:0] source_sample = 16'h0000;
  logic [15:0] smp_q = 16'h0000;
  logic        prev_cs = 1'b0;
  logic        prev_tk = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  logic        sample_tick, capture_strobe, triggered, recording_done;
  int          err_total = 0;
  int          total_checks = 0;
  // es = FFFF: trigger sample value not checked
  rtl_row_t    rows [7] = '{
    '{2'h0, 1'b0, 7'h32, 16'h0014, 16'h0001, 16'h0000, 1'b0, 16'hFFFF},
    '{2'h1, 1'b0, 7'h00, 16'h000A, 16'h0001, 16'h0000, 1'b0, 16'hFFFF},
    '{2'h2, 1'b1, 7'h00, 16'h0010, 16'h0002, 16'h0003, 1'b0, 16'h0003},
    '{2'h2, 1'b0, 7'h00, 16'h0010, 16'h0001, 16'h0003, 1'b0, 16'h0000},
    '{2'h2, 1'b1, 7'h19, 16'h0014, 16'h0002, 16'h0003, 1'b0, 16'hFFFF},
    '{2'h3, 1'b1, 7'h00, 16'h0008, 16'h0001, 16'h7FFF, 1'b1, 16'hFFFF},
    '{2'h3, 1'b0, 7'h4B, 16'h0008, 16'h0001, 16'h0000, 1'b0, 16'hFFFF}};

  initial forever #4 pclk = ~pclk;

  rtl_host_model u_rtl_host_model (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  rtl_trigger #(.SW(16), .CW(16), .TICK_CYCLES(4)) u_rtl_trigger (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .source_sample(source_sample), .source_bit(source_bit),
    .sample_tick(sample_tick), .capture_strobe(capture_strobe), .triggered(triggered),
    .recording_done(recording_done));

  // sawtooth 0..9 stepping once a sample, held as the sample that last fed the trigger
  always @(posedge pclk) begin
    if (sample_tick) source_sample <= (source_sample == 16'h0009) ? 16'h0000 : source_sample + 16'h0001;
    if (sample_tick && !triggered) smp_q <= source_sample;
    prev_cs <= capture_strobe;
    prev_tk <= sample_tick;
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_rtl_host_model.xfer(1'b1, a, d, q, e);
    if (e === 1'bx) begin
      err_total++;
      results();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    u_rtl_host_model.xfer(1'b0, a, 32'h0, q, e);
    if (e === 1'bx) begin
      err_total++;
      results();
    end
  endtask

  task automatic run_row(input rtl_row_t r);
    logic [31:0] idx;
    int          post;
    logic        seen;
    idx = (r.ty == `RTL_TYPE_IMMED) ? 32'h0 : (32'(r.cnt) * 32'(r.pct)) / 32'd100;
    post = 0;
    seen = 1'b0;
    wr(`RTL_OFF_CMD, 32'h4);
    wr(`RTL_OFF_CTRL, {17'h0, r.pct, 5'h0, r.pol, r.ty});
    wr(`RTL_OFF_THRESH, {16'h0, r.thr});
    wr(`RTL_OFF_COUNT, {16'h0, r.cnt});
    wr(`RTL_OFF_DECIM, {16'h0, r.dec});
    source_bit <= r.sb;
    wr(`RTL_OFF_CMD, 32'h1);
    if (r.ty == `RTL_TYPE_NEXTCMD) begin
      repeat (12) @(negedge pclk);
      chk("early trigger", 32'h0, 32'(triggered));
      wr(`RTL_OFF_THRESH, 32'h0);
    end
    for (int i = 0; i < 3000 && recording_done !== 1'b1; i++) begin
      @(negedge pclk);
      if (triggered === 1'b1 && !seen) begin
        seen = 1'b1;
        if (r.ty == `RTL_TYPE_SIGNAL) chk("eval slot", 32'h1, 32'((r.pct == 0) ? prev_tk : prev_cs));
        if (r.es != 16'hFFFF) chk("trigger sample", {16'h0, r.es}, {16'h0, smp_q});
      end
      if (triggered === 1'b1 && recording_done !== 1'b1 && capture_strobe === 1'b1) post++;
    end
    if (recording_done !== 1'b1) begin
      err_total++;
      results();
    end
    chk("post share", 32'(r.cnt) - idx, 32'(post));
    rd(`RTL_OFF_TRIGIDX);
    chk("pre share", idx, q);
    rd(`RTL_OFF_STATUS);
    chk("status done", 32'h10, q);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k]) run_row(rows[k]);
    u_rtl_host_model.xfer(1'b1, 12'h040, 32'hFFFF_FFFF, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    // boolean positive with a low source must sit waiting, threshold has no say
    wr(`RTL_OFF_CMD, 32'h4);
    wr(`RTL_OFF_CTRL, 32'h0000_0007);
    wr(`RTL_OFF_THRESH, 32'h0000_0000);
    source_bit <= 1'b0;
    wr(`RTL_OFF_CMD, 32'h1);
    wr(`RTL_OFF_COUNT, 32'h0000_0005);
    repeat (20) @(negedge pclk);
    chk("bool low", 32'h0, 32'(triggered));
    rd(`RTL_OFF_COUNT);
    chk("count locked", 32'h8, q);
    wr(`RTL_OFF_CMD, 32'h4);
    rd(`RTL_OFF_STATUS);
    chk("abort idle", 32'h1, q);
    wr(`RTL_OFF_CMD, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset trig", 32'h0, {30'h0, triggered, recording_done});
    rd(`RTL_OFF_STATUS);
    chk("reset status", 32'h1, q);
    rd(`RTL_OFF_COUNT);
    chk("reset count", 32'(`RTL_RST_COUNT), q);
    rd(`RTL_OFF_DECIM);
    chk("reset decim", 32'(`RTL_RST_DECIM), q);
    results();
  end
endmodule
